// [bench/prwc_props.sv]
// Port checker for the power, reset and wakeup controller.
// Assumes binding onto prwc_top; one clock domain.
`timescale 1ns/100ps
module prwc_props
(
    input wire logic REF_CLK_IN, RST_B_IN, PSEL_IN, PENABLE_IN, PREADY_OUT, PSLVERR_OUT,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic BROWNOUT_LEVEL_SELECT_IN, RESET_PIN_SELECT_IN, RST_PIN_B_IN, WATCHDOG_ALWAYS_ON_IN,
    input wire logic WDT_OVF_IN, CRYSTAL_MODE_IN, INT_RESET_OUT, BO_IRQ_OUT, OSC_EN_OUT, CPU_RUN_OUT,
    input wire logic PERIPH_CLK_EN_OUT, BO_HIGH_LEVEL_OUT, EPROM_LOW_POWER_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    logic [10:0] cnt_r;
    logic wake_r;
    // Cycles since the oscillator restarted after deep sleep
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            cnt_r <= 11'h000;
            wake_r <= 1'b0;
        end
        else
        begin
            cnt_r <= OSC_EN_OUT ? cnt_r + 11'h001 : 11'h000;
            wake_r <= !OSC_EN_OUT | (wake_r & !CPU_RUN_OUT);
        end
    end
    // Reset sources held long enough to cross the synchroniser
    sequence s_pin_low;
        !RESET_PIN_SELECT_IN && !RST_PIN_B_IN;
    endsequence
    sequence s_wdt_ovf;
        WATCHDOG_ALWAYS_ON_IN && WDT_OVF_IN;
    endsequence
    a_ready_after_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT) else $error("no ready");
    a_err_zero_data: assert property (PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0) else $error("bad err");
    a_level_low: assert property (BROWNOUT_LEVEL_SELECT_IN [*4] |-> !BO_HIGH_LEVEL_OUT)
        else $error("level low");
    a_level_high: assert property (!BROWNOUT_LEVEL_SELECT_IN [*4] |-> BO_HIGH_LEVEL_OUT)
        else $error("level high");
    a_pin_reset: assert property (s_pin_low [*4] |-> INT_RESET_OUT) else $error("pin reset");
    a_wdt_reset: assert property (s_wdt_ovf [*4] |-> INT_RESET_OUT) else $error("wdt reset");
    a_irq_single: assert property (BO_IRQ_OUT |=> !BO_IRQ_OUT) else $error("irq pulse");
    a_deep_halt: assert property (!OSC_EN_OUT |-> !CPU_RUN_OUT && !PERIPH_CLK_EN_OUT)
        else $error("deep halt");
    a_run_clocks: assert property (CPU_RUN_OUT |-> PERIPH_CLK_EN_OUT && OSC_EN_OUT) else $error("run");
    a_eprom_keep: assert property (EPROM_LOW_POWER_OUT |=> EPROM_LOW_POWER_OUT) else $error("eprom");
    a_stab_count: assert property ($rose(CPU_RUN_OUT) && wake_r |-> (CRYSTAL_MODE_IN ?
        (cnt_r > 11'h3fe && cnt_r < 11'h404) : (cnt_r > 11'h0fe && cnt_r < 11'h104))) else $error("stab");
endmodule
bind prwc_top prwc_props i_prwc_props (.*);

// [bench/tb_top.sv]
// Self-checking bench for the power, reset and wakeup controller.
// Assumes prwc_top with its checker bound; the bench is the APB master.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: %h / %h", $time, g, e); end end
module tb_top;
    import prwc_pkg::*;
    logic REF_CLK_IN = 1'b0, RST_B_IN = 1'b0, PSEL_IN = 1'b0, PENABLE_IN = 1'b0, PWRITE_IN = 1'b0;
    logic [11:0] PADDR_IN = 12'h000;
    logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT;
    logic PREADY_OUT, PSLVERR_OUT, INT_RESET_OUT, BO_IRQ_OUT, OSC_EN_OUT, CPU_RUN_OUT;
    logic PERIPH_CLK_EN_OUT, BO_DET_EN_OUT, BO_HIGH_LEVEL_OUT, EPROM_LOW_POWER_OUT;
    logic BROWNOUT_LEVEL_SELECT_IN = 1'b1, RESET_PIN_SELECT_IN = 1'b1, WATCHDOG_ALWAYS_ON_IN = 1'b0;
    logic CRYSTAL_MODE_IN = 1'b0, BO_LOW_DET_IN = 1'b0, BO_HIGH_DET_IN = 1'b0, POWER_ON_DET_IN = 1'b0;
    logic RST_PIN_B_IN = 1'b1, WDT_OVF_IN = 1'b0, WDT_IRQ_IN = 1'b0, ABOVE_PRIO_IN = 1'b0;
    logic [4:0] IRQ_REQ_IN = 5'h00, SRC_READY_IN = 5'h00;
    logic [32:0] notes[$];
    logic [32:0] note_v;
    int bad_count = 0, n_tests = 0, seed = 32'he48c, n;
    prwc_top i_prwc_top (.*);
    // Clock and hang guard
    initial
    begin
        forever #2 REF_CLK_IN = ~REF_CLK_IN;
    end
    initial
    begin
        #120000;
        bad_count++;
        conclude();
    end
    // Compares each read answer with the oldest note
    always @(negedge REF_CLK_IN)
    begin
        if (PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN && notes.size() > 0)
        begin
            note_v = notes.pop_front();
            `CHK({PSLVERR_OUT, PRDATA_OUT}, note_v)
        end
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge REF_CLK_IN);
    endtask
    task automatic hold();
        repeat (6) @(posedge REF_CLK_IN);
        @(negedge REF_CLK_IN);
    endtask
    // One APB transfer; a read notes {error, data} as expected
    task automatic apb(input logic wr, input logic [11:0] a, input logic [32:0] e);
        @(posedge REF_CLK_IN);
        PSEL_IN <= 1'b1;
        PWRITE_IN <= wr;
        PADDR_IN <= a;
        PWDATA_IN <= e[31:0];
        if (!wr)
        begin
            notes.push_back(e);
        end
        @(posedge REF_CLK_IN);
        PENABLE_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        while (PREADY_OUT !== 1'b1)
        begin
            @(posedge REF_CLK_IN);
        end
        PSEL_IN <= 1'b0;
        PENABLE_IN <= 1'b0;
    endtask
    task automatic conclude();
        $display("compared %0d, wrong %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence
    initial
    begin
        cyc(3);
        RST_B_IN <= 1'b1;
        apb(0, 12'h000, 33'h10);
        apb(0, 12'h014, 33'h100000000);
        apb(1, 12'h000, 33'h0);
        apb(0, 12'h000, 33'h0);
        POWER_ON_DET_IN <= 1'b1;
        cyc(4);
        POWER_ON_DET_IN <= 1'b0;
        apb(0, 12'h000, 33'h10);
        apb(1, 12'h000, 33'h0);
        $display("done: reset");
        SRC_READY_IN <= 5'h1f;
        apb(1, 12'h00c, 33'h7f);
        apb(1, 12'h000, 33'h1);
        apb(0, 12'h010, 33'h1);
        @(negedge REF_CLK_IN);
        `CHK({PERIPH_CLK_EN_OUT, CPU_RUN_OUT}, 2'b10)
        cyc(1);
        IRQ_REQ_IN <= 5'h01;
        cyc(6);
        IRQ_REQ_IN <= 5'h00;
        apb(0, 12'h000, 33'h0);
        $display("done: light sleep");
        for (int i = 0; i < 6; i++)
        begin
            n = $random(seed);
            CRYSTAL_MODE_IN <= n[0];
            apb(1, 12'h00c, 33'h1 << i);
            apb(1, 12'h000, 33'h2);
            SRC_READY_IN <= 5'h00;
            ABOVE_PRIO_IN <= 1'b0;
            {WDT_IRQ_IN, IRQ_REQ_IN} <= 6'h3f;
            cyc(8);
            apb(0, 12'h010, 33'h2);
            @(negedge REF_CLK_IN);
            `CHK(OSC_EN_OUT, 1'b0)
            cyc(1);
            SRC_READY_IN <= 5'h1f;
            ABOVE_PRIO_IN <= 1'b1;
            n = 0;
            while (CPU_RUN_OUT !== 1'b1 && n < 2000)
            begin
                @(negedge REF_CLK_IN);
                n++;
            end
            `CHK(n > (CRYSTAL_MODE_IN ? 1024 : 256) && n < (CRYSTAL_MODE_IN ? 1033 : 265), 1'b1)
            cyc(1);
            {WDT_IRQ_IN, IRQ_REQ_IN} <= 6'h00;
            apb(0, 12'h000, 33'h0);
        end
        $display("done: deep sleep");
        apb(1, 12'h008, 33'h20);
        apb(1, 12'h00c, 33'h40);
        apb(1, 12'h000, 33'h2);
        BO_LOW_DET_IN <= 1'b1;
        n = 0;
        repeat (40)
        begin
            @(negedge REF_CLK_IN);
            n += BO_IRQ_OUT;
        end
        `CHK(n, 1)
        `CHK(INT_RESET_OUT, 1'b0)
        cyc(1100);
        apb(0, 12'h000, 33'h20);
        BO_LOW_DET_IN <= 1'b0;
        $display("done: brownout wake");
        apb(1, 12'h004, 33'h10);
        apb(1, 12'h004, 33'h0);
        apb(0, 12'h004, 33'h10);
        `CHK(EPROM_LOW_POWER_OUT, 1'b1)
        $display("done: eprom");
        apb(1, 12'h008, 33'h0);
        BROWNOUT_LEVEL_SELECT_IN <= 1'b0;
        BO_HIGH_DET_IN <= 1'b1;
        hold();
        `CHK({BO_HIGH_LEVEL_OUT, INT_RESET_OUT}, 2'b11)
        cyc(1);
        BO_HIGH_DET_IN <= 1'b0;
        cyc(6);
        apb(1, 12'h008, 33'h40);
        BO_HIGH_DET_IN <= 1'b1;
        hold();
        `CHK({BO_DET_EN_OUT, INT_RESET_OUT}, 2'b00)
        $display("done: brownout reset");
        cyc(1);
        BO_HIGH_DET_IN <= 1'b0;
        RST_PIN_B_IN <= 1'b0;
        hold();
        `CHK(INT_RESET_OUT, 1'b0)
        cyc(1);
        RESET_PIN_SELECT_IN <= 1'b0;
        hold();
        `CHK(INT_RESET_OUT, 1'b1)
        cyc(1);
        RST_PIN_B_IN <= 1'b1;
        hold();
        `CHK(INT_RESET_OUT, 1'b0)
        cyc(1);
        WATCHDOG_ALWAYS_ON_IN <= 1'b1;
        WDT_OVF_IN <= 1'b1;
        hold();
        `CHK(INT_RESET_OUT, 1'b1)
        $display("done: reset sources");
        conclude();
    end
endmodule

// [core/prwc_pkg.sv]
// Constants for the power, reset and wakeup controller.
// Assumes an APB master on the 250 MHz reference clock.
package prwc_pkg;
    // Register byte offsets
    localparam logic [11:0] PRWC_PWR_CTRL_OFS = 12'h000;
    localparam logic [11:0] PRWC_AUX_CTRL_OFS = 12'h004;
    localparam logic [11:0] PRWC_AUX_CTRL1_OFS = 12'h008;
    localparam logic [11:0] PRWC_WAKE_EN_OFS = 12'h00c;
    localparam logic [11:0] PRWC_STATUS_OFS = 12'h010;
    // Power control fields
    localparam int PRWC_IDLE_BIT = 0;
    localparam int PRWC_PDN_BIT = 1;
    localparam int PRWC_BO_FLAG_BIT = 5;
    localparam int PRWC_PU_FLAG_BIT = 4;
    // Aux control fields
    localparam int PRWC_EPROM_LP_BIT = 4;
    localparam int PRWC_BO_IRQSEL_BIT = 5;
    localparam int PRWC_BO_DIS_BIT = 6;
    // Wake enable fields (interrupt enables)
    localparam int PRWC_WE_EXT0 = 0;
    localparam int PRWC_WE_EXT1 = 1;
    localparam int PRWC_WE_KBD = 2;
    localparam int PRWC_WE_CMP1 = 3;
    localparam int PRWC_WE_CMP2 = 4;
    localparam int PRWC_WE_WDT = 5;
    localparam int PRWC_WE_BO = 6;
    localparam int PRWC_WE_W = 7;
    // Oscillator stabilisation counts
    localparam logic [10:0] PRWC_XTAL_CNT = 11'h400;
    localparam logic [10:0] PRWC_RC_CNT = 11'h100;
    localparam logic [10:0] PRWC_CNT_ONE = 11'h001;
    // Sleep states
    typedef enum logic [1:0]
    {
        PRWC_RUN = 2'b00,
        PRWC_LIGHT = 2'b01,
        PRWC_DEEP = 2'b10,
        PRWC_STAB = 2'b11
    } prwc_state_e;
endpackage

// [core/prwc_sync.sv]
// Two-flop synchroniser for a bank of asynchronous levels.
// Assumes inputs are quasi-static levels from pins or analog blocks.
`timescale 1ns/100ps
module prwc_sync #(parameter int W = 1)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1_r;
    // Two stages, first read only by the second
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s1_r <= '0;
            q_out <= '0;
        end
        else
        begin
            s1_r <= d_in;
            q_out <= s1_r;
        end
    end
endmodule

// [core/prwc_top.sv]
// Power supervision, sleep control, wakeup qualification and reset generation.
// Assumes APB on REF_CLK_IN; RST_B_IN is the power-on reset; detectors are async.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module prwc_top
(
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic BROWNOUT_LEVEL_SELECT_IN,
    input wire logic RESET_PIN_SELECT_IN,
    input wire logic WATCHDOG_ALWAYS_ON_IN,
    input wire logic CRYSTAL_MODE_IN,
    input wire logic BO_LOW_DET_IN,
    input wire logic BO_HIGH_DET_IN,
    input wire logic POWER_ON_DET_IN,
    input wire logic RST_PIN_B_IN,
    input wire logic WDT_OVF_IN,
    input wire logic [4:0] IRQ_REQ_IN,
    input wire logic [4:0] SRC_READY_IN,
    input wire logic WDT_IRQ_IN,
    input wire logic ABOVE_PRIO_IN,
    output logic INT_RESET_OUT,
    output logic BO_IRQ_OUT,
    output logic OSC_EN_OUT,
    output logic CPU_RUN_OUT,
    output logic PERIPH_CLK_EN_OUT,
    output logic BO_DET_EN_OUT,
    output logic BO_HIGH_LEVEL_OUT,
    output logic EPROM_LOW_POWER_OUT
);
    import prwc_pkg::*;

    // Synchronised asynchronous inputs
    logic [15:0] async_raw;
    logic [15:0] async_s;
    assign async_raw = {CRYSTAL_MODE_IN, WATCHDOG_ALWAYS_ON_IN,
                        ABOVE_PRIO_IN, WDT_IRQ_IN, SRC_READY_IN[4:0] & IRQ_REQ_IN[4:0],
                        WDT_OVF_IN, RST_PIN_B_IN, POWER_ON_DET_IN, BO_HIGH_DET_IN, BO_LOW_DET_IN,
                        RESET_PIN_SELECT_IN, BROWNOUT_LEVEL_SELECT_IN};
    prwc_sync #(.W(16)) u_sync
    (
        .clk_in(REF_CLK_IN),
        .rst_b_in(RST_B_IN),
        .d_in(async_raw),
        .q_out(async_s)
    );

    wire lvl_sel = async_s[0];
    wire pin_sel = async_s[1];
    wire bo_low = async_s[2];
    wire bo_high = async_s[3];
    wire por_det = async_s[4];
    wire pin_b = async_s[5];
    wire wdt_ovf = async_s[6];
    wire [4:0] src_irq = async_s[11:7];
    wire wdt_irq = async_s[12];
    wire above_prio = async_s[13];
    wire wdt_always_on = async_s[14];
    wire crystal_mode = async_s[15];

    // Registers
    logic idle_r, idle_nxt;
    logic pdn_r, pdn_nxt;
    logic pu_flag_r, pu_flag_nxt;
    logic bo_flag_r, bo_flag_nxt;
    logic eprom_lp_r, eprom_lp_nxt;
    logic bo_irqsel_r, bo_irqsel_nxt;
    logic bo_dis_r, bo_dis_nxt;
    logic [6:0] wake_en_r, wake_en_nxt;
    logic bo_prev_r;
    logic [10:0] stab_cnt_r, stab_cnt_nxt;
    prwc_state_e state_r, state_nxt;

    // APB decode
    wire apb_acc = PSEL_IN && PENABLE_IN;
    wire apb_wr = apb_acc && PWRITE_IN;
    wire hit_pc = PADDR_IN == PRWC_PWR_CTRL_OFS;
    wire hit_aux = PADDR_IN == PRWC_AUX_CTRL_OFS;
    wire hit_aux1 = PADDR_IN == PRWC_AUX_CTRL1_OFS;
    wire hit_we = PADDR_IN == PRWC_WAKE_EN_OFS;
    wire hit_st = PADDR_IN == PRWC_STATUS_OFS;
    wire hit_any = hit_pc || hit_aux || hit_aux1 || hit_we || hit_st;
    wire wr_pc = apb_wr && hit_pc;
    wire wr_aux = apb_wr && hit_aux;
    wire wr_aux1 = apb_wr && hit_aux1;
    wire wr_we = apb_wr && hit_we;

    // Brownout detection: threshold select and disable
    wire bo_below = lvl_sel ? bo_low : bo_high;
    wire bo_active = !bo_dis_r && bo_below;
    wire bo_fall = bo_active && !bo_prev_r;
    wire bo_rst = bo_active && !bo_irqsel_r;
    wire bo_irq = bo_fall && bo_irqsel_r && wake_en_r[PRWC_WE_BO];

    // Wakeup qualification
    wire [4:0] src_en = wake_en_r[PRWC_WE_CMP2:PRWC_WE_EXT0];
    wire src_wake = |(src_irq & src_en);
    wire wdt_irq_wake = !wdt_always_on && wdt_irq && wake_en_r[PRWC_WE_WDT];
    wire wdt_rst = wdt_always_on && wdt_ovf;
    wire bo_wake = bo_irq;
    wire any_irq = src_wake || wdt_irq_wake || bo_wake;
    wire deep_wake_irq = any_irq && above_prio;
    wire pin_rst = !pin_sel && !pin_b;
    wire int_rst = bo_rst || wdt_rst || pin_rst;

    // Stabilisation count by oscillator type
    wire [10:0] stab_len = crystal_mode ? PRWC_XTAL_CNT : PRWC_RC_CNT;

    // Sleep state machine
    always_comb
    begin
        state_nxt = state_r;
        stab_cnt_nxt = stab_cnt_r;
        unique case (state_r)
            PRWC_RUN:
            begin
                if (pdn_r)
                    state_nxt = PRWC_DEEP;
                else if (idle_r)
                    state_nxt = PRWC_LIGHT;
            end
            PRWC_LIGHT:
            begin
                if (any_irq || int_rst)
                    state_nxt = PRWC_RUN;
            end
            PRWC_DEEP:
            begin
                if (deep_wake_irq || int_rst)
                begin
                    state_nxt = PRWC_STAB;
                    stab_cnt_nxt = stab_len;
                end
            end
            PRWC_STAB:
            begin
                if (stab_cnt_r == PRWC_CNT_ONE)
                    state_nxt = PRWC_RUN;
                stab_cnt_nxt = stab_cnt_r - PRWC_CNT_ONE;
            end
        endcase
    end

    wire leave_light = state_r == PRWC_LIGHT && state_nxt == PRWC_RUN;
    wire leave_deep = state_r == PRWC_DEEP && state_nxt == PRWC_STAB;

    // Register next values; hardware set wins over software clear
    always_comb
    begin
        idle_nxt = idle_r;
        pdn_nxt = pdn_r;
        pu_flag_nxt = pu_flag_r;
        bo_flag_nxt = bo_flag_r;
        eprom_lp_nxt = eprom_lp_r;
        bo_irqsel_nxt = bo_irqsel_r;
        bo_dis_nxt = bo_dis_r;
        wake_en_nxt = wake_en_r;
        if (wr_pc)
        begin
            idle_nxt = PWDATA_IN[PRWC_IDLE_BIT];
            pdn_nxt = PWDATA_IN[PRWC_PDN_BIT];
            pu_flag_nxt = pu_flag_r && PWDATA_IN[PRWC_PU_FLAG_BIT];
            bo_flag_nxt = bo_flag_r && PWDATA_IN[PRWC_BO_FLAG_BIT];
        end
        if (leave_light)
            idle_nxt = 1'b0;
        if (leave_deep)
            pdn_nxt = 1'b0;
        if (por_det)
            pu_flag_nxt = 1'b1;
        if (bo_active)
            bo_flag_nxt = 1'b1;
        if (wr_aux && PWDATA_IN[PRWC_EPROM_LP_BIT])
            eprom_lp_nxt = 1'b1;
        if (wr_aux1)
        begin
            bo_irqsel_nxt = PWDATA_IN[PRWC_BO_IRQSEL_BIT];
            bo_dis_nxt = PWDATA_IN[PRWC_BO_DIS_BIT];
        end
        if (wr_we)
            wake_en_nxt = PWDATA_IN[PRWC_WE_W-1:0];
    end

    // Read mux
    wire [31:0] rd_pc = (32'({bo_flag_r, pu_flag_r}) << PRWC_PU_FLAG_BIT) | 32'({pdn_r, idle_r});
    wire [31:0] rd_aux = 32'(eprom_lp_r) << PRWC_EPROM_LP_BIT;
    wire [31:0] rd_aux1 = 32'({bo_dis_r, bo_irqsel_r}) << PRWC_BO_IRQSEL_BIT;
    wire [31:0] rd_we = 32'(wake_en_r);
    wire [31:0] rd_st = 32'({bo_active, int_rst, state_r});
    wire [31:0] rd_data = hit_pc ? rd_pc : hit_aux ? rd_aux : hit_aux1 ? rd_aux1 :
                          hit_we ? rd_we : hit_st ? rd_st : 32'h0000_0000;

    // Control and status flops; only power-on reset clears them, except pu_flag_r, which it sets
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            idle_r <= 1'b0;
            pdn_r <= 1'b0;
            pu_flag_r <= 1'b1;
            bo_flag_r <= 1'b0;
            eprom_lp_r <= 1'b0;
            bo_irqsel_r <= 1'b0;
            bo_dis_r <= 1'b0;
            wake_en_r <= 7'h00;
            bo_prev_r <= 1'b0;
            stab_cnt_r <= 11'h000;
            state_r <= PRWC_RUN;
        end
        else
        begin
            idle_r <= idle_nxt;
            pdn_r <= pdn_nxt;
            pu_flag_r <= pu_flag_nxt;
            bo_flag_r <= bo_flag_nxt;
            eprom_lp_r <= eprom_lp_nxt;
            bo_irqsel_r <= bo_irqsel_nxt;
            bo_dis_r <= bo_dis_nxt;
            wake_en_r <= wake_en_nxt;
            bo_prev_r <= bo_active;
            stab_cnt_r <= stab_cnt_nxt;
            state_r <= state_nxt;
        end
    end

    // Registered outputs
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            PRDATA_OUT <= 32'h0000_0000;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            INT_RESET_OUT <= 1'b1;
            BO_IRQ_OUT <= 1'b0;
            OSC_EN_OUT <= 1'b1;
            CPU_RUN_OUT <= 1'b0;
            PERIPH_CLK_EN_OUT <= 1'b1;
            BO_DET_EN_OUT <= 1'b1;
            BO_HIGH_LEVEL_OUT <= 1'b0;
            EPROM_LOW_POWER_OUT <= 1'b0;
        end
        else
        begin
            PREADY_OUT <= PSEL_IN && !PENABLE_IN;
            PRDATA_OUT <= (PSEL_IN && !PENABLE_IN && !PWRITE_IN) ? rd_data : 32'h0000_0000;
            PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !hit_any;
            INT_RESET_OUT <= int_rst;
            BO_IRQ_OUT <= bo_irq;
            OSC_EN_OUT <= state_nxt != PRWC_DEEP;
            CPU_RUN_OUT <= state_nxt == PRWC_RUN && !int_rst;
            PERIPH_CLK_EN_OUT <= state_nxt == PRWC_RUN || state_nxt == PRWC_LIGHT;
            BO_DET_EN_OUT <= !bo_dis_nxt;
            BO_HIGH_LEVEL_OUT <= !lvl_sel;
            EPROM_LOW_POWER_OUT <= eprom_lp_nxt;
        end
    end
endmodule
